// ===== rtl/nfc_pkg.sv
// Package for the native flow control block: field layouts, bus map, carriers.
// Assumes a single 40 MHz user clock and a 32-bit AXI4-Lite register bus.
package nfc_pkg;

  // Request word layout, little-endian bit numbering
  localparam int unsigned LE_PAUSE_LSB = 0;
  localparam int unsigned LE_STOP_BIT = 8;
  // Big-endian layout: ascending bits 8:15 pause, bit 7 stop, seen as [0:15]
  localparam int unsigned BE_PAUSE_POS = 8;
  localparam int unsigned BE_STOP_POS = 7;
  localparam int unsigned PAUSE_W = 8;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PAUSE_LEFT = 8'h08;

  // Control field positions
  localparam int unsigned CTRL_LITTLE_END = 0;
  localparam int unsigned CTRL_COMPLETION = 1;
  localparam int unsigned CTRL_ENABLE = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

  // Status field positions
  localparam int unsigned ST_STOP_ALL = 0;
  localparam int unsigned ST_PAUSING = 1;
  localparam int unsigned ST_PENDING = 2;
  localparam int unsigned ST_IN_FRAME = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Outgoing slot states
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_GAP
  } nfc_tx_e;

  // Decoded request from either party
  typedef struct packed {
    logic stop_all;
    logic [PAUSE_W-1:0] pause;
  } nfc_req_s;

endpackage

// ===== rtl/nfc_core.sv
// Native flow control: takes local pause/stop requests for the partner and
// throttles the local transmit data path on requests from the partner.
// Assumes the user side, the receive path and the bus all run on ref_clk.
// Summary of operation
// - Core raises request ready when it takes the pending request for sending.
// - Big-endian word: bits 8:15 pause count, bit 7 stop-all, 0:6 ignored.
// - Little-endian word: bits 7:0 pause count, bit 8 stop-all, 15:9 ignored.
// - A received pause withholds data for at least pause count plus one cycles.
// - Received stop-all halts data until a non-stop request or reset.
// - All-zero request is the resume code; afterwards any request is honored.
// - No data beside an outgoing message; data ready drops the cycle after ready.
// - Data ready drops for exactly one cycle to make room for the message.
// - Immediate mode: a received pause drops data ready at once for its length.
// - Completion mode: idles only before a new frame; mid-frame waits to end.
// - Completion mode only with framing; streaming builds force immediate mode.
// - Bit ordering chosen at configuration; big-endian is the default.
// - All interface signals are active high except the active-low reset arst_n.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module nfc_core #(
  parameter bit FRAMING = 1'b1,
  parameter bit LITTLE_END_DEFAULT = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Local request towards the partner
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [15:0] req_data,
  // Outgoing message to the link encoder
  output logic msg_tx_valid,
  output nfc_pkg::nfc_req_s msg_tx,
  // Message received from the partner
  input wire logic msg_rx_valid,
  input wire logic [15:0] msg_rx_data,
  // Local transmit data path
  input wire logic data_valid,
  input wire logic data_last,
  output logic data_ready,
  // AXI4-Lite slave: write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [31:0] ctrl_q;
  logic little_end;
  logic completion;
  logic enable;
  nfc_pkg::nfc_tx_e tx_q;
  nfc_pkg::nfc_req_s rx_req;
  logic [nfc_pkg::PAUSE_W:0] pause_q;
  logic stop_q;
  logic pend_q;
  logic [nfc_pkg::PAUSE_W-1:0] pend_pause_q;
  logic in_frame_q;
  logic take;
  logic throttle;
  logic beat;
  logic frame_start_ok;

  // Word decode for either bit ordering
  function automatic nfc_pkg::nfc_req_s decode(input logic [15:0] w, input logic le);
    nfc_pkg::nfc_req_s r;
    r = '0;
    if (le) begin
      r.pause = w[nfc_pkg::LE_PAUSE_LSB +: nfc_pkg::PAUSE_W];
      r.stop_all = w[nfc_pkg::LE_STOP_BIT];
    end else begin
      // Ascending bit n of the bus sits on wire 15-n
      for (int i = 0; i < nfc_pkg::PAUSE_W; i++) begin
        r.pause[nfc_pkg::PAUSE_W-1-i] = w[15-(nfc_pkg::BE_PAUSE_POS+i)];
      end
      r.stop_all = w[15-nfc_pkg::BE_STOP_POS];
    end
    return r;
  endfunction

  assign little_end = ctrl_q[nfc_pkg::CTRL_LITTLE_END];
  // Streaming builds cannot select completion mode
  assign completion = FRAMING & ctrl_q[nfc_pkg::CTRL_COMPLETION];
  assign enable = ctrl_q[nfc_pkg::CTRL_ENABLE];
  assign rx_req = decode(msg_rx_data, little_end);

  // Local request: taken only in an idle slot so each message gets its own gap
  assign take = req_valid & enable & (tx_q == nfc_pkg::TX_IDLE);
  assign req_ready = take;

  // A taken request always costs exactly one gap cycle, never more
  nfc_pkg::nfc_tx_e tx_d;
  always_comb begin
    tx_d = nfc_pkg::TX_IDLE;
    case (tx_q)
      nfc_pkg::TX_IDLE: begin
        if (take) begin
          tx_d = nfc_pkg::TX_GAP;
        end
      end
      nfc_pkg::TX_GAP: begin
        tx_d = nfc_pkg::TX_IDLE;
      end
      default: begin
        tx_d = nfc_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= nfc_pkg::TX_IDLE;
    end else begin
      tx_q <= tx_d;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_tx_valid <= 1'b0;
      msg_tx <= '0;
    end else begin
      msg_tx_valid <= take;
      if (take) begin
        msg_tx <= decode(req_data, little_end);
      end
    end
  end

  // Frame tracking for completion mode
  assign beat = data_valid & data_ready;
  // A frame is open from its first accepted beat until its last
  logic in_frame_d;
  always_comb begin
    in_frame_d = in_frame_q;
    if (beat) begin
      in_frame_d = !data_last;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= in_frame_d;
    end
  end

  // A received pause is applied between frames in completion mode
  assign frame_start_ok = !completion || !in_frame_q;

  // Next state of the receive throttle
  logic stop_d;
  logic [nfc_pkg::PAUSE_W:0] pause_d;
  logic pend_d;
  logic [nfc_pkg::PAUSE_W-1:0] pend_pause_d;
  logic last_beat;
  logic apply_ok;

  assign last_beat = beat & data_last;
  // Loading on the last beat keeps the first beat of the next frame out
  assign apply_ok = frame_start_ok | last_beat;

  always_comb begin
    stop_d = stop_q;
    pause_d = pause_q;
    pend_d = pend_q;
    pend_pause_d = pend_pause_q;
    if (msg_rx_valid) begin
      // Any non-stop request, resume code included, lifts stop-all
      stop_d = rx_req.stop_all;
      if (!rx_req.stop_all && rx_req.pause != '0) begin
        if (apply_ok) begin
          // Count plus one cycles without data
          pause_d = {1'b0, rx_req.pause} + 9'h001;
          pend_d = 1'b0;
        end else begin
          pend_d = 1'b1;
          pend_pause_d = rx_req.pause;
        end
      end else begin
        pause_d = '0;
        pend_d = 1'b0;
      end
    end else if (pend_q && apply_ok) begin
      pause_d = {1'b0, pend_pause_q} + 9'h001;
      pend_d = 1'b0;
    end else if (pause_q != '0) begin
      pause_d = pause_q - 9'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_q <= 1'b0;
      pause_q <= '0;
      pend_q <= 1'b0;
      pend_pause_q <= '0;
    end else begin
      stop_q <= stop_d;
      pause_q <= pause_d;
      pend_q <= pend_d;
      pend_pause_q <= pend_pause_d;
    end
  end

  // Resume code costs no idle cycle; in completion mode stop and pause only gate frame starts
  assign throttle = stop_q || pause_q != '0;
  assign data_ready = (tx_q == nfc_pkg::TX_IDLE)
    && !(throttle && frame_start_ok);

  // AXI4-Lite: write address and data may arrive in either order
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_ctrl;
  logic wr_ro;

  // Read-only registers answer OKAY and drop the data
  assign wr_ctrl = awaddr_q[7:2] == nfc_pkg::REG_CTRL[7:2];
  assign wr_ro = awaddr_q[7:2] == nfc_pkg::REG_STATUS[7:2]
    || awaddr_q[7:2] == nfc_pkg::REG_PAUSE_LEFT[7:2];

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= nfc_pkg::RESP_OKAY;
      ctrl_q <= nfc_pkg::CTRL_RESET | {31'h0000_0000, LITTLE_END_DEFAULT};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_ctrl || wr_ro) begin
          s_axi_bresp <= nfc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= nfc_pkg::RESP_SLVERR;
        end
        if (wr_ctrl && wstrb_q[0]) begin
          ctrl_q[7:0] <= {5'h00, wdata_q[2:0]};
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Read mux: unmapped offsets read zero with an error response
  logic [31:0] rd_word;
  logic [1:0] rd_resp;
  logic [3:0] status_w;
  assign status_w = {in_frame_q, pend_q, pause_q != '0, stop_q};
  always_comb begin
    rd_word = '0;
    rd_resp = nfc_pkg::RESP_OKAY;
    case (s_axi_araddr[7:2])
      nfc_pkg::REG_CTRL[7:2]: begin
        rd_word = {29'h0000_0000, enable, completion, little_end};
      end
      nfc_pkg::REG_STATUS[7:2]: begin
        rd_word = {28'h000_0000, status_w};
      end
      nfc_pkg::REG_PAUSE_LEFT[7:2]: begin
        rd_word = {23'h00_0000, pause_q};
      end
      default: begin
        rd_word = '0;
        rd_resp = nfc_pkg::RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= nfc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/nfc_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== verif/nfc_core_sva.sv
// Port-level timing checks for the flow control core.
// Assumes binding onto nfc_core and a single ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module nfc_core_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic msg_tx_valid,
  input wire logic msg_rx_valid,
  input wire logic [15:0] msg_rx_data,
  input wire logic data_valid,
  input wire logic data_last,
  input wire logic data_ready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic in_frame_q;
  logic calm;
  logic take;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      in_frame_q <= 1'b0;
    else if (data_valid && data_ready)
      in_frame_q <= !data_last;
  end
  // Completion mode may defer a message that lands inside a frame
  assign calm = msg_rx_valid && !in_frame_q && !data_valid;
  assign take = req_valid && req_ready;
  property p_ready_valid; req_ready |-> req_valid; endproperty
  a_ready_valid: assert property (p_ready_valid) else $error("ready without valid");
  property p_tx_slot; take |=> msg_tx_valid; endproperty
  a_tx_slot: assert property (p_tx_slot) else $error("no message slot");
  property p_gap; take |=> !data_ready; endproperty
  a_gap: assert property (p_gap) else $error("data beside message");
  property p_single; msg_tx_valid |-> !req_ready ##1 !msg_tx_valid; endproperty
  a_single: assert property (p_single) else $error("slot too long");
  property p_stop; calm && msg_rx_data[8] |=> (!data_ready) [*8]; endproperty
  a_stop: assert property (p_stop) else $error("stop not held");
  property p_pause1; calm && msg_rx_data == 16'h0001 |=> (!data_ready) [*2]; endproperty
  a_pause1: assert property (p_pause1) else $error("pause too short");
  property p_resume; calm && msg_rx_data[8:0] == 9'h000 && !take |=> data_ready; endproperty
  a_resume: assert property (p_resume) else $error("resume not honored");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_take: cover property (take);
  c_stop: cover property (calm && msg_rx_data[8]);
  c_frame: cover property (in_frame_q && msg_rx_valid);
endmodule
bind nfc_core nfc_core_chk i_nfc_core_chk (.ref_clk, .arst_n, .req_valid, .req_ready,
  .msg_tx_valid, .msg_rx_valid, .msg_rx_data, .data_valid, .data_last, .data_ready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// ===== verif/nfc_user_model.sv
// User application side that issues flow control requests.
// Assumes go is a one-cycle command from the bench on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module nfc_user_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Command from the bench
  input wire logic go,
  input wire logic [15:0] word,
  // Request port
  input wire logic req_ready,
  output logic req_valid,
  output logic [15:0] req_data
);
  // Released word is inverted so a stale value can never look valid
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_valid <= 1'b0;
      req_data <= 16'h0000;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req_data <= ~req_data;
    end else if (go && !req_valid) begin
      req_valid <= 1'b1;
      req_data <= word;
    end
  end
endmodule
`default_nettype wire

// ===== verif/nfc_core_tb.sv
// Self-checking bench for the flow control core.
// Assumes the user model drives requests and the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module nfc_core_tb;
  logic ref_clk, arst_n, req_valid, req_ready, msg_tx_valid, msg_rx_valid, go;
  logic data_valid, data_last, data_ready, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] req_data, msg_rx_data, word;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  nfc_pkg::nfc_req_s msg_tx;
  int failures, checked, n;
  nfc_core i_nfc_core (.ref_clk, .arst_n, .req_valid, .req_ready, .req_data, .msg_tx_valid,
    .msg_tx, .msg_rx_valid, .msg_rx_data, .data_valid, .data_last, .data_ready, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  nfc_user_model i_nfc_user_model (.ref_clk, .arst_n, .go, .word, .req_ready, .req_valid,
    .req_data);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, nfc_pkg::RESP_OKAY);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Waits for the take of word w, then checks the slot and the one-cycle gap
  task automatic take_check(input logic [15:0] w);
    n = 0;
    while (!(req_valid && req_ready) && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    check("slot", msg_tx_valid, 1'b1);
    check("msg", msg_tx, {w[8], w[7:0]});
    check("gap", data_ready, 1'b0);
    @(posedge ref_clk);
    #1;
    check("gap end", data_ready, 1'b1);
  endtask
  task automatic t_send(input logic [15:0] w, input logic off);
    @(posedge ref_clk);
    word <= w;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    if (off) begin
      repeat (5) @(posedge ref_clk);
      check("refused", req_ready, 1'b0);
      axi_wr(nfc_pkg::REG_CTRL, nfc_pkg::CTRL_RESET);
    end
    take_check(w);
  endtask
  task automatic t_rx(input logic [15:0] w, input int exp);
    @(posedge ref_clk);
    msg_rx_data <= w;
    msg_rx_valid <= 1'b1;
    @(posedge ref_clk);
    msg_rx_valid <= 1'b0;
    #1;
    n = 0;
    while (data_ready !== 1'b1 && n < 40) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    check("idle cycles", n, exp);
  endtask
  // A pause that lands mid-frame must wait for the last beat
  task automatic t_comp();
    axi_wr(nfc_pkg::REG_CTRL, 32'h0000_0006);
    @(posedge ref_clk);
    data_valid <= 1'b1;
    @(posedge ref_clk);
    data_valid <= 1'b0;
    msg_rx_valid <= 1'b1;
    msg_rx_data <= 16'h0002;
    @(posedge ref_clk);
    msg_rx_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("deferred", data_ready, 1'b1);
    data_valid <= 1'b1;
    data_last <= 1'b1;
    @(posedge ref_clk);
    data_valid <= 1'b0;
    data_last <= 1'b0;
    n = 0;
    repeat (10) begin
      @(posedge ref_clk);
      n += !data_ready;
    end
    check("frame idles", n, 3);
    axi_wr(nfc_pkg::REG_CTRL, nfc_pkg::CTRL_RESET);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #500000;
    failures++;
    wrap_up();
  end
  initial begin
    {arst_n, go, msg_rx_valid, data_valid, data_last, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {word, msg_rx_data, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    axi_rd(nfc_pkg::REG_CTRL);
    check("ctrl reset", rd, nfc_pkg::CTRL_RESET);
    axi_rd(8'h40);
    check("unmapped", {rs, rd}, {nfc_pkg::RESP_SLVERR, 32'h0000_0000});
    t_send(16'h0105, 1'b0);
    t_send(16'h00FF, 1'b0);
    axi_wr(nfc_pkg::REG_CTRL, 32'h0000_0000);
    t_send(16'h0003, 1'b1);
    t_rx(16'h0001, 2);
    t_rx(16'h0100, 40);
    axi_rd(nfc_pkg::REG_STATUS);
    check("stop status", rd, 32'h0000_0001);
    t_rx(16'h0000, 0);
    t_rx(16'h0002, 3);
    axi_wr(nfc_pkg::REG_CTRL, 32'h0000_0005);
    t_rx(16'h0003, 4);
    t_send(16'h0107, 1'b0);
    axi_wr(nfc_pkg::REG_CTRL, nfc_pkg::CTRL_RESET);
    t_comp();
    wrap_up();
  end
endmodule
`default_nettype wire
